// >>> shared/user_pin_pkg.sv
package user_pin_pkg;

    // register locations: byte-wide special registers and extended-space registers
    localparam logic [7:0] SFR_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] SFR_USER_PIN_DATA = 8'h90;
    localparam logic [7:0] SFR_USER_PIN_DIRECTION = 8'h91;
    localparam logic [15:0] XRAM_SELECT_PINS01 = 16'hFF90;
    localparam logic [15:0] XRAM_SELECT_PINS23 = 16'hFF91;
    localparam logic [15:0] XRAM_SELECT_PINS45 = 16'hFF92;
    localparam logic [15:0] XRAM_SELECT_PINS67 = 16'hFF93;

    // reset values
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] DATA_RESET = 8'hFF;
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // field layout
    localparam logic [7:0] SELECT_USED_MASK = 8'h77;
    localparam int CODE_WIDTH = 3;
    localparam int CODE_LSB_EVEN_PIN = 0;
    localparam int CODE_LSB_ODD_PIN = 4;
    localparam int IRQ0_TYPE_BIT = 0;
    localparam int IRQ1_TYPE_BIT = 2;
    localparam logic [7:0] TIMER_CONTROL_USED_MASK = 8'h05;
    localparam int PIN_COUNT = 8;
    localparam int SELECT_REG_COUNT = 4;

    typedef enum logic [2:0] {
        RES_NONE_A = 3'b000,
        RES_NONE_B = 3'b001,
        RES_TIMER0 = 3'b010,
        RES_TIMER1 = 3'b011,
        RES_IRQ0_HIGH = 3'b100,
        RES_IRQ1_HIGH = 3'b101,
        RES_IRQ0_LOW = 3'b110,
        RES_IRQ1_LOW = 3'b111
    } pin_resource_code_type;

    typedef struct packed {
        logic sfr_sel;
        logic xram_sel;
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic timer0_gate_clock;
        logic timer1_gate_clock;
        logic irq0;
        logic irq1;
    } resource_type;

    // code field of one pin out of the four packed select registers
    function automatic logic [2:0] pin_code(input logic [31:0] sel, input int pin);
        logic [7:0] byte_v;
        byte_v = sel[(pin / 2) * 8 +: 8];
        if (pin % 2 == 0)
        begin
            pin_code = byte_v[CODE_LSB_EVEN_PIN +: CODE_WIDTH];
        end
        else
        begin
            pin_code = byte_v[CODE_LSB_ODD_PIN +: CODE_WIDTH];
        end
    endfunction : pin_code

endpackage : user_pin_pkg

// >>> verilog/pin_sync_bank.sv
`timescale 1ns/1ps
module pin_sync_bank
    import user_pin_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_sync_out
);
    logic [7:0] stage1_q;
    logic [7:0] stage2_q;

    // two flops; the first is read by the second only
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            stage1_q <= 8'h00;
            stage2_q <= 8'h00;
        end
        else if (ce_in)
        begin
            stage1_q <= pin_in;
            stage2_q <= stage1_q;
        end
    end

    assign pin_sync_out = stage2_q;

endmodule : pin_sync_bank

// >>> verilog/pin_resource_router.sv
`timescale 1ns/1ps
module pin_resource_router
    import user_pin_pkg::*;
(
    input wire logic [7:0] pin_level_in,
    input wire logic [31:0] select_in,
    output resource_type resource_out
);
    // one bit per pin whose select field equals the given code
    function automatic logic [7:0] pins_with(input logic [31:0] sel, input logic [2:0] code);
        logic [7:0] m;
        m = 8'h00;
        for (int p = 0; p < PIN_COUNT; p++)
        begin
            m[p] = (pin_code(sel, p) == code);
        end
        pins_with = m;
    endfunction : pins_with

    wire logic [7:0] t0_pins = pins_with(select_in, RES_TIMER0);
    wire logic [7:0] t1_pins = pins_with(select_in, RES_TIMER1);
    wire logic [7:0] i0_hi_pins = pins_with(select_in, RES_IRQ0_HIGH);
    wire logic [7:0] i1_hi_pins = pins_with(select_in, RES_IRQ1_HIGH);
    wire logic [7:0] i0_lo_pins = pins_with(select_in, RES_IRQ0_LOW);
    wire logic [7:0] i1_lo_pins = pins_with(select_in, RES_IRQ1_LOW);

    // codes 0 and 1 match none of the masks above, so such pins feed nothing
    assign resource_out.timer0_gate_clock = |(t0_pins & pin_level_in);
    assign resource_out.timer1_gate_clock = |(t1_pins & pin_level_in);
    assign resource_out.irq0 = |(i0_hi_pins & pin_level_in) | |(i0_lo_pins & ~pin_level_in);
    assign resource_out.irq1 = |(i1_hi_pins & pin_level_in) | |(i1_lo_pins & ~pin_level_in);

endmodule : pin_resource_router

// >>> verilog/user_pin_port.sv
// What this block does
// - all eight pins are inputs after reset
// - direction bit per pin: 0 output, 1 input
// - data read gives pins, write drives outputs
// - pull-ups on until first direction write
// - four select registers, two 3-bit codes each
// - codes 0,1 none; 2 timer0; 3 timer1
// - codes 4,5 feed pin to irq0/irq1
// - codes 6,7 feed inverted pin to irq0/irq1
// - several pins on one resource are ORed
// - edge or level from timer control bits
// - select pins01 resets zero, fields 2:0, 6:4
// - select pins23 resets zero, same layout
// - select pins45/67 reset zero, same layout
// - irq0 type bit 0, irq1 type bit 2
`timescale 1ns/1ps
module user_pin_port
    import user_pin_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire reg_req_type req_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n_out,
    output logic pullup_en_out,
    output logic timer0_gate_clock_out,
    output logic timer1_gate_clock_out,
    output logic ext_irq0_out,
    output logic ext_irq1_out,
    output logic ext_irq0_type_out,
    output logic ext_irq1_type_out
);
    logic [7:0] user_pin_data_q;
    logic [7:0] user_pin_direction_q;
    logic pullup_q;
    logic [7:0] select_q [SELECT_REG_COUNT];
    logic [7:0] timer_control_q;
    logic [7:0] rd_data_q;
    logic rd_valid_q;
    resource_type res_q;
    resource_type res_prev_q;
    logic irq0_q;
    logic irq1_q;
    logic [7:0] pin_sync;
    resource_type res_comb;

    // address decode
    wire logic sfr_wr = req_in.sfr_sel & req_in.wr;
    wire logic xram_wr = req_in.xram_sel & req_in.wr;
    wire logic hit_data = req_in.sfr_sel && req_in.addr[7:0] == SFR_USER_PIN_DATA;
    wire logic hit_dir = req_in.sfr_sel && req_in.addr[7:0] == SFR_USER_PIN_DIRECTION;
    wire logic hit_timer_control_reg = req_in.sfr_sel && req_in.addr[7:0] == SFR_TIMER_CONTROL;
    wire logic [15:0] sel_base = XRAM_SELECT_PINS01;
    wire logic [15:0] sel_offset = req_in.addr - sel_base;
    wire logic hit_sel = req_in.xram_sel && req_in.addr >= XRAM_SELECT_PINS01
        && req_in.addr <= XRAM_SELECT_PINS67;
    wire logic [1:0] sel_index = sel_offset[1:0];
    wire logic wr_data = sfr_wr & hit_data;
    wire logic wr_dir = sfr_wr & hit_dir;
    wire logic wr_timer_control_reg = sfr_wr & hit_timer_control_reg;
    wire logic wr_sel = xram_wr & hit_sel;
    wire logic [31:0] select_flat = {select_q[3], select_q[2], select_q[1], select_q[0]};

    wire logic [7:0] rd_mux =
        hit_data ? pin_sync :
        hit_dir ? user_pin_direction_q :
        hit_timer_control_reg ? (timer_control_q & TIMER_CONTROL_USED_MASK) :
        hit_sel ? (select_q[sel_index] & SELECT_USED_MASK) :
        READ_UNMAPPED;

    pin_sync_bank u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .pin_in(pin_in),
        .pin_sync_out(pin_sync)
    );

    pin_resource_router u_router (
        .pin_level_in(pin_sync),
        .select_in(select_flat),
        .resource_out(res_comb)
    );

    // port data and direction
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            user_pin_data_q <= DATA_RESET;
            user_pin_direction_q <= DIRECTION_RESET;
            pullup_q <= 1'b1;
        end
        else if (ce_in)
        begin
            if (wr_data)
            begin
                user_pin_data_q <= req_in.wdata;
            end
            if (wr_dir)
            begin
                user_pin_direction_q <= req_in.wdata;
                pullup_q <= 1'b0;
            end
        end
    end

    // resource select registers
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < SELECT_REG_COUNT; i++)
            begin
                select_q[i] <= SELECT_RESET;
            end
        end
        else if (ce_in && wr_sel)
        begin
            select_q[sel_index] <= req_in.wdata & SELECT_USED_MASK;
        end
    end

    // interrupt type bits; the rest of that register lives elsewhere
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            timer_control_q <= TIMER_CONTROL_RESET;
        end
        else if (ce_in && wr_timer_control_reg)
        begin
            timer_control_q <= req_in.wdata & TIMER_CONTROL_USED_MASK;
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rd_data_q <= READ_UNMAPPED;
            rd_valid_q <= 1'b0;
        end
        else if (ce_in)
        begin
            rd_valid_q <= req_in.rd & (req_in.sfr_sel | req_in.xram_sel);
            if (req_in.rd)
            begin
                rd_data_q <= rd_mux;
            end
        end
    end

    wire logic irq0_edge_mode = timer_control_q[IRQ0_TYPE_BIT];
    wire logic irq1_edge_mode = timer_control_q[IRQ1_TYPE_BIT];
    wire logic irq0_next = irq0_edge_mode ? (res_q.irq0 & ~res_prev_q.irq0) : res_q.irq0;
    wire logic irq1_next = irq1_edge_mode ? (res_q.irq1 & ~res_prev_q.irq1) : res_q.irq1;

    // routed resources and interrupt request shaping
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            res_q <= '0;
            res_prev_q <= '0;
            irq0_q <= 1'b0;
            irq1_q <= 1'b0;
        end
        else if (ce_in)
        begin
            res_q <= res_comb;
            res_prev_q <= res_q;
            irq0_q <= irq0_next;
            irq1_q <= irq1_next;
        end
    end

    assign rd_data_out = rd_data_q;
    assign rd_valid_out = rd_valid_q;
    assign pin_out = user_pin_data_q;
    assign pin_oe_n_out = user_pin_direction_q;
    assign pullup_en_out = pullup_q;
    assign timer0_gate_clock_out = res_q.timer0_gate_clock;
    assign timer1_gate_clock_out = res_q.timer1_gate_clock;
    assign ext_irq0_out = irq0_q;
    assign ext_irq1_out = irq1_q;
    assign ext_irq0_type_out = timer_control_q[IRQ0_TYPE_BIT];
    assign ext_irq1_type_out = timer_control_q[IRQ1_TYPE_BIT];

endmodule : user_pin_port

// >>> tb/user_pin_port_sva.sv
`timescale 1ns/1ps
module user_pin_port_sva
    import user_pin_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire reg_req_type req_in,
    input wire logic [7:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n_out,
    input wire logic pullup_en_out,
    input wire logic ext_irq0_out,
    input wire logic ext_irq0_type_out,
    input wire logic ext_irq1_type_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    wire sfr_wr = ce_in && req_in.wr && req_in.sfr_sel;
    wire rd_any = ce_in && req_in.rd && (req_in.sfr_sel || req_in.xram_sel);
    wire [7:0] a8 = req_in.addr[7:0];
    chk_read_answer: assert property (rd_any |=> rd_valid_out)
        else $error("read not answered");
    chk_reset_inputs: assert property ($fell(rst_in) |-> pin_oe_n_out == 8'hFF && pullup_en_out)
        else $error("pins not inputs after reset");
    chk_dir_write: assert property (sfr_wr && a8 == SFR_USER_PIN_DIRECTION |=>
        pin_oe_n_out == $past(req_in.wdata) && !pullup_en_out) else $error("direction write lost");
    chk_data_write: assert property (sfr_wr && a8 == SFR_USER_PIN_DATA |=>
        pin_out == $past(req_in.wdata)) else $error("data write lost");
    chk_pullup_hold: assert property (!pullup_en_out |=> !pullup_en_out)
        else $error("pull-up came back");
    chk_type_bits: assert property (sfr_wr && a8 == SFR_TIMER_CONTROL |=>
        {ext_irq1_type_out, ext_irq0_type_out} == {$past(req_in.wdata[2]), $past(req_in.wdata[0])})
        else $error("type bits wrong");
    chk_sel_unused: assert property (rd_any && req_in.xram_sel && req_in.addr[15:2] == 14'h3FE4
        |=> (rd_data_out & 8'h88) == 8'h00) else $error("unused select bits set");
    chk_pin_read: assert property (rd_any && req_in.sfr_sel && a8 == SFR_USER_PIN_DATA
        && $stable(pin_in) && pin_in == $past(pin_in, 2) && !$past(rst_in) && !$past(rst_in, 2)
        && $past(ce_in) && $past(ce_in, 2)
        |=> rd_data_out == $past(pin_in)) else $error("pin read wrong");
    chk_edge_pulse: assert property (ext_irq0_type_out && ext_irq0_out |=>
        !ext_irq0_out || !ext_irq0_type_out) else $error("edge irq longer than a cycle");
    cover property (rd_valid_out);
    cover property ($rose(ext_irq0_out) && ext_irq0_type_out);
    cover property ($fell(pullup_en_out));
endmodule : user_pin_port_sva

// >>> tb/pin_board_model.sv
`timescale 1ns/1ps
module pin_board_model (
    input wire logic clk_in,
    input wire logic [7:0] dev_level_in,
    input wire logic [7:0] dev_oe_n_in,
    input wire logic pullup_in,
    input wire logic [7:0] drive_en_in,
    input wire logic [7:0] drive_val_in,
    output logic [7:0] pin_level_out
);
    logic [7:0] float_q = 8'h00;
    always_ff @(posedge clk_in)
    begin
        float_q <= ~float_q;
    end
    // board drives only pins that the device leaves as inputs
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!dev_oe_n_in[i])
                pin_level_out[i] = dev_level_in[i];
            else if (drive_en_in[i])
                pin_level_out[i] = drive_val_in[i];
            else
                pin_level_out[i] = pullup_in ? 1'b1 : float_q[i];
        end
    end
endmodule : pin_board_model

// >>> tb/user_pin_port_tb.sv
`timescale 1ns/1ps
module user_pin_port_tb
    import user_pin_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    reg_req_type req_in = '0;
    logic [7:0] drive_en = 8'hF0;
    logic [7:0] drive_val = 8'h00;
    logic [7:0] pin_in, rd_data_out, pin_out, pin_oe_n_out, v;
    logic rd_valid_out, pullup_en_out, timer0_gate_clock_out, timer1_gate_clock_out;
    logic ext_irq0_out, ext_irq1_out, ext_irq0_type_out, ext_irq1_type_out;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    wire [7:0] res_now = {4'h0, timer0_gate_clock_out, timer1_gate_clock_out, ext_irq0_out,
        ext_irq1_out};
    always #5 clk_in = ~clk_in;
    user_pin_port DUT (.clk_in, .rst_in, .ce_in, .req_in, .rd_data_out, .rd_valid_out, .pin_in,
        .pin_out, .pin_oe_n_out, .pullup_en_out, .timer0_gate_clock_out, .timer1_gate_clock_out,
        .ext_irq0_out, .ext_irq1_out, .ext_irq0_type_out, .ext_irq1_type_out);
    pin_board_model board (.clk_in, .dev_level_in(pin_out), .dev_oe_n_in(pin_oe_n_out),
        .pullup_in(pullup_en_out), .drive_en_in(drive_en), .drive_val_in(drive_val),
        .pin_level_out(pin_in));
    function automatic logic [7:0] res_exp(input logic [2:0] c, input logic p);
        return {4'h0, c == 3'd2 && p, c == 3'd3 && p, (c == 3'd4 && p) || (c == 3'd6 && !p),
            (c == 3'd5 && p) || (c == 3'd7 && !p)};
    endfunction : res_exp
    task automatic tally_and_finish();
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [7:0] seen, input logic [7:0] e);
        n_checks++;
        if (seen !== e)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, e);
        end
    endtask : chk
    task automatic access(input logic xr, input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req_in <= {!xr, xr, w, !w, a, d};
        @(posedge clk_in);
        req_in <= '0;
        #1;
    endtask : access
    task automatic rd(input logic xr, input logic [15:0] a, input logic [7:0] e);
        access(xr, 1'b0, a, 8'h00);
        chk({7'h00, rd_valid_out}, 8'h01);
        chk(rd_data_out, e);
    endtask : rd
    task automatic drive(input logic [7:0] val);
        @(posedge clk_in);
        drive_val <= val;
        repeat (4) @(posedge clk_in);
        #1;
    endtask : drive
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            errors = errors + 1;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        chk(pin_oe_n_out, 8'hFF);
        chk({7'h00, pullup_en_out}, 8'h01);
        for (int i = 0; i < 4; i++)
            rd(1'b1, XRAM_SELECT_PINS01 + 16'(i), SELECT_RESET);
        // pins 7:4 held low by the board, pins 3:0 float up on the pull-ups
        rd(1'b0, 16'(SFR_USER_PIN_DATA), 8'h0F);
        @(posedge clk_in);
        ce_in <= 1'b0;
        access(1'b0, 1'b1, 16'(SFR_USER_PIN_DIRECTION), 8'h00);
        chk(pin_oe_n_out, 8'hFF);
        @(posedge clk_in);
        ce_in <= 1'b1;
        #1;
        access(1'b0, 1'b1, 16'(SFR_USER_PIN_DATA), 8'hA5);
        access(1'b0, 1'b1, 16'(SFR_USER_PIN_DIRECTION), 8'hF0);
        chk(pin_out, 8'hA5);
        chk(pin_oe_n_out, 8'hF0);
        chk({7'h00, pullup_en_out}, 8'h00);
        drive(8'h30);
        rd(1'b0, 16'(SFR_USER_PIN_DATA), 8'h35);
        rd(1'b1, 16'hFF98, READ_UNMAPPED);
        for (int i = 0; i < 4; i++)
        begin
            access(1'b1, 1'b1, XRAM_SELECT_PINS01 + 16'(i), 8'hFF);
            rd(1'b1, XRAM_SELECT_PINS01 + 16'(i), SELECT_USED_MASK);
            access(1'b1, 1'b1, XRAM_SELECT_PINS01 + 16'(i), 8'h00);
        end
        for (int c = 0; c < 8; c++)
        begin
            access(1'b1, 1'b1, XRAM_SELECT_PINS67, {1'b0, 3'(c), 4'h0});
            for (int b = 0; b < 2; b++)
            begin
                drive({1'(b), 7'h00});
                chk(res_now, res_exp(3'(c), 1'(b)));
            end
        end
        access(1'b1, 1'b1, XRAM_SELECT_PINS67, 8'h00);
        access(1'b1, 1'b1, XRAM_SELECT_PINS45, 8'h22);
        drive(8'h10);
        chk(res_now, 8'h08);
        drive(8'h20);
        chk(res_now, 8'h08);
        drive(8'h00);
        chk(res_now, 8'h00);
        access(1'b0, 1'b1, 16'(SFR_TIMER_CONTROL), 8'hFF);
        rd(1'b0, 16'(SFR_TIMER_CONTROL), 8'h05);
        access(1'b1, 1'b1, XRAM_SELECT_PINS45, 8'h04);
        @(posedge clk_in);
        drive_val <= 8'h10;
        v = 8'h00;
        repeat (8)
        begin
            @(posedge clk_in);
            #1;
            v = v + 8'(ext_irq0_out);
        end
        chk(v, 8'h01);
        access(1'b0, 1'b1, 16'(SFR_TIMER_CONTROL), 8'h00);
        drive(8'h10);
        chk(res_now, 8'h02);
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        chk(pin_oe_n_out, 8'hFF);
        chk(res_now, 8'h00);
        tally_and_finish();
    end
endmodule : user_pin_port_tb
bind user_pin_port user_pin_port_sva chk_u (.clk_in, .rst_in, .ce_in, .req_in, .rd_data_out,
    .rd_valid_out, .pin_in, .pin_out, .pin_oe_n_out, .pullup_en_out, .ext_irq0_out,
    .ext_irq0_type_out, .ext_irq1_type_out);
